// file: src/regfile_pkg.sv
package regfile_pkg;

    // Register counts and widths.
    localparam int NUM_REGS = 8;
    localparam int STACK_INDEX = 7;
    localparam int PTR_WIDTH = 24;

    // Operand sizes selected per access.
    typedef enum logic [1:0] {
        SIZE_BYTE,
        SIZE_WORD,
        SIZE_LONG
    } op_size_e;

    // Sub-register selection for byte and word accesses.
    localparam logic [1:0] SEL_LOW_BYTE = 2'h0;
    localparam logic [1:0] SEL_HIGH_BYTE = 2'h1;
    localparam logic [1:0] SEL_LOW_WORD = 2'h2;
    localparam logic [1:0] SEL_EXT_WORD = 2'h3;

    // Condition flag bit positions.
    localparam int FLAG_I = 7;
    localparam int FLAG_USER_BIT_SIX = 6;
    localparam int FLAG_H = 5;
    localparam int FLAG_U = 4;
    localparam int FLAG_N = 3;
    localparam int FLAG_Z = 2;
    localparam int FLAG_V = 1;
    localparam int FLAG_C = 0;

    // Half-carry positions per operand size.
    localparam int HC_BIT_BYTE = 3;
    localparam int HC_BIT_WORD = 11;
    localparam int HC_BIT_LONG = 27;

    // Values after reset.
    localparam logic [7:0] FLAGS_RESET = 8'h80;
    localparam logic [23:0] PTR_RESET = 24'h000000;
    localparam logic [31:0] GEN_RESET = 32'h00000000;

    // Control instruction operations on the condition flags.
    typedef enum logic [2:0] {
        CTL_NONE,
        CTL_LOAD,
        CTL_AND,
        CTL_OR,
        CTL_XOR
    } ctl_op_e;

endpackage : regfile_pkg

// file: src/cpu_register_file_pc_ccr.sv
`timescale 1ns/1ns

module cpu_register_file_pc_ccr (
    // Clock and reset.
    input wire logic mclk,
    input wire logic rst_n,
    // Read port A.
    input wire logic [2:0] rd_a_index,
    input wire regfile_pkg::op_size_e rd_a_size,
    input wire logic [1:0] rd_a_sel,
    output logic [31:0] rd_a_data,
    // Read port B.
    input wire logic [2:0] rd_b_index,
    input wire regfile_pkg::op_size_e rd_b_size,
    input wire logic [1:0] rd_b_sel,
    output logic [31:0] rd_b_data,
    // Write port.
    input wire logic wr_en,
    input wire logic [2:0] wr_index,
    input wire regfile_pkg::op_size_e wr_size,
    input wire logic [1:0] wr_sel,
    input wire logic [31:0] wr_data,
    // Stack pointer update for implicit pushes and pops.
    input wire logic stack_wr_en,
    input wire logic [31:0] stack_wr_data,
    output logic [31:0] stack_pointer,
    // Next instruction pointer.
    input wire logic ptr_load,
    input wire logic [23:0] ptr_load_data,
    input wire logic vector_load,
    input wire logic [23:0] vector_data,
    output logic [23:0] next_instruction_pointer,
    output logic [23:0] fetch_addr,
    // Condition flag control instructions.
    input wire regfile_pkg::ctl_op_e ctl_op,
    input wire logic [7:0] ctl_imm,
    output logic [7:0] condition_flags,
    // Flag update from an arithmetic result.
    input wire logic alu_flags_en,
    input wire regfile_pkg::op_size_e alu_size,
    input wire logic [31:0] alu_result,
    input wire logic alu_hc_en,
    input wire logic [31:0] alu_op_a,
    input wire logic [31:0] alu_op_b,
    input wire logic alu_sub,
    input wire logic alu_v,
    input wire logic alu_c_en,
    input wire logic alu_c,
    // Exception entry and interrupt gating.
    input wire logic exc_start,
    input wire logic irq_pending,
    input wire logic nmi_pending,
    output logic irq_accept,
    // Branch condition evaluation.
    input wire logic [3:0] cond_code,
    output logic cond_true
);

    logic [31:0] gen_reg [regfile_pkg::NUM_REGS];
    logic [23:0] ptr_reg;
    logic [7:0] flags_reg;

    // Narrow read extraction, zero extended into the low bits of the port.
    function automatic logic [31:0] read_view(input logic [31:0] r,
                                              input regfile_pkg::op_size_e sz,
                                              input logic [1:0] sel);
        logic [31:0] v;
        v = r;
        if (sz == regfile_pkg::SIZE_BYTE) begin
            v = (sel == regfile_pkg::SEL_HIGH_BYTE) ? {24'h000000, r[15:8]}
                                                     : {24'h000000, r[7:0]};
        end else if (sz == regfile_pkg::SIZE_WORD) begin
            v = (sel == regfile_pkg::SEL_EXT_WORD) ? {16'h0000, r[31:16]}
                                                    : {16'h0000, r[15:0]};
        end
        return v;
    endfunction : read_view

    // Merge a narrow write so untouched bits keep their old value.
    function automatic logic [31:0] write_merge(input logic [31:0] r,
                                                input regfile_pkg::op_size_e sz,
                                                input logic [1:0] sel,
                                                input logic [31:0] d);
        logic [31:0] v;
        v = d;
        if (sz == regfile_pkg::SIZE_BYTE) begin
            if (sel == regfile_pkg::SEL_HIGH_BYTE) begin
                v = {r[31:16], d[7:0], r[7:0]};
            end else begin
                v = {r[31:8], d[7:0]};
            end
        end else if (sz == regfile_pkg::SIZE_WORD) begin
            if (sel == regfile_pkg::SEL_EXT_WORD) begin
                v = {d[15:0], r[15:0]};
            end else begin
                v = {r[31:16], d[15:0]};
            end
        end
        return v;
    endfunction : write_merge

    // Carry or borrow out of a given bit, recovered from operands and result.
    function automatic logic carry_out_of(input logic [31:0] a,
                                          input logic [31:0] b,
                                          input logic [31:0] res,
                                          input logic sub,
                                          input int pos);
        logic [31:0] bb;
        bb = sub ? ~b : b;
        return (a[pos+1] ^ bb[pos+1] ^ res[pos+1]) ^ sub;
    endfunction : carry_out_of

    // General registers; the explicit write port wins over an implicit stack update
    // to the same register because the instruction result is the newer value.
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            for (int i = 0; i < regfile_pkg::NUM_REGS; i++) begin
                gen_reg[i] <= regfile_pkg::GEN_RESET;
            end
        end else begin
            if (stack_wr_en) begin
                gen_reg[regfile_pkg::STACK_INDEX] <= stack_wr_data;
            end
            if (wr_en) begin
                gen_reg[wr_index] <= write_merge(gen_reg[wr_index], wr_size, wr_sel,
                                                 wr_data);
            end
        end
    end

    // Two independent read ports, each with its own width and half select.
    assign rd_a_data = read_view(gen_reg[rd_a_index], rd_a_size, rd_a_sel);
    assign rd_b_data = read_view(gen_reg[rd_b_index], rd_b_size, rd_b_sel);
    assign stack_pointer = gen_reg[regfile_pkg::STACK_INDEX];

    // Instruction pointer; the vector fetch of the reset sequence has priority.
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            ptr_reg <= regfile_pkg::PTR_RESET;
        end else if (vector_load) begin
            ptr_reg <= vector_data;
        end else if (ptr_load) begin
            ptr_reg <= ptr_load_data;
        end
    end

    assign next_instruction_pointer = ptr_reg;
    // Instructions are whole words, so the odd address bit never reaches the bus.
    assign fetch_addr = {ptr_reg[23:1], 1'b0};

    // Size-dependent result flags, declared before the flag register reads them.
    logic alu_n;
    logic alu_z;
    logic alu_h;

    // Flag register. Only the mask bit has a defined reset value; the others are
    // cleared here too so simulation never carries unknowns into branches.
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            flags_reg <= regfile_pkg::FLAGS_RESET;
        end else begin
            case (ctl_op)
                regfile_pkg::CTL_LOAD: flags_reg <= ctl_imm;
                regfile_pkg::CTL_AND: flags_reg <= flags_reg & ctl_imm;
                regfile_pkg::CTL_OR: flags_reg <= flags_reg | ctl_imm;
                regfile_pkg::CTL_XOR: flags_reg <= flags_reg ^ ctl_imm;
                default: begin
                    if (alu_flags_en) begin
                        // User bits are untouched by arithmetic.
                        flags_reg[regfile_pkg::FLAG_N] <= alu_n;
                        flags_reg[regfile_pkg::FLAG_Z] <= alu_z;
                        flags_reg[regfile_pkg::FLAG_V] <= alu_v;
                        if (alu_hc_en) begin
                            flags_reg[regfile_pkg::FLAG_H] <= alu_h;
                        end
                        if (alu_c_en) begin
                            flags_reg[regfile_pkg::FLAG_C] <= alu_c;
                        end
                    end
                end
            endcase
            if (exc_start) begin
                flags_reg[regfile_pkg::FLAG_I] <= 1'b1;
            end
        end
    end

    assign condition_flags = flags_reg;

    // Size-dependent result flags.
    always_comb begin
        case (alu_size)
            regfile_pkg::SIZE_BYTE: begin
                alu_n = alu_result[7];
                alu_z = (alu_result[7:0] == 8'h00);
                alu_h = carry_out_of(alu_op_a, alu_op_b, alu_result, alu_sub,
                                     regfile_pkg::HC_BIT_BYTE);
            end
            regfile_pkg::SIZE_WORD: begin
                alu_n = alu_result[15];
                alu_z = (alu_result[15:0] == 16'h0000);
                alu_h = carry_out_of(alu_op_a, alu_op_b, alu_result, alu_sub,
                                     regfile_pkg::HC_BIT_WORD);
            end
            default: begin
                alu_n = alu_result[31];
                alu_z = (alu_result == 32'h00000000);
                alu_h = carry_out_of(alu_op_a, alu_op_b, alu_result, alu_sub,
                                     regfile_pkg::HC_BIT_LONG);
            end
        endcase
    end

    // Interrupt gating; the non-maskable source ignores the mask.
    assign irq_accept = nmi_pending
        | (irq_pending & ~flags_reg[regfile_pkg::FLAG_I]);

    // Branch conditions in the usual sixteen-way encoding.
    logic fn;
    logic fz;
    logic fv;
    logic fc;
    assign fn = flags_reg[regfile_pkg::FLAG_N];
    assign fz = flags_reg[regfile_pkg::FLAG_Z];
    assign fv = flags_reg[regfile_pkg::FLAG_V];
    assign fc = flags_reg[regfile_pkg::FLAG_C];
    always_comb begin
        case (cond_code)
            4'h0: cond_true = 1'b1;
            4'h1: cond_true = 1'b0;
            4'h2: cond_true = ~(fc | fz);
            4'h3: cond_true = fc | fz;
            4'h4: cond_true = ~fc;
            4'h5: cond_true = fc;
            4'h6: cond_true = ~fz;
            4'h7: cond_true = fz;
            4'h8: cond_true = ~fv;
            4'h9: cond_true = fv;
            4'ha: cond_true = ~fn;
            4'hb: cond_true = fn;
            4'hc: cond_true = ~(fn ^ fv);
            4'hd: cond_true = fn ^ fv;
            4'he: cond_true = ~(fz | (fn ^ fv));
            default: cond_true = fz | (fn ^ fv);
        endcase
    end

endmodule : cpu_register_file_pc_ccr

// file: test/regfile_asserts.sv
`timescale 1ns/1ns

// Cycle relations at the register file ports; data paths are left to the bench model.
module regfile_asserts (
    // Clock and reset.
    input wire logic mclk,
    input wire logic rst_n,
    // Watched ports.
    input wire logic wr_en,
    input wire logic stack_wr_en,
    input wire logic [31:0] stack_wr_data,
    input wire logic [31:0] stack_pointer,
    input wire logic vector_load,
    input wire logic [23:0] vector_data,
    input wire logic [23:0] next_instruction_pointer,
    input wire logic [23:0] fetch_addr,
    input wire regfile_pkg::ctl_op_e ctl_op,
    input wire logic [7:0] ctl_imm,
    input wire logic [7:0] condition_flags,
    input wire logic alu_flags_en,
    input wire regfile_pkg::op_size_e alu_size,
    input wire logic [31:0] alu_result,
    input wire logic exc_start,
    input wire logic irq_pending,
    input wire logic nmi_pending,
    input wire logic irq_accept
);
    default clocking @(posedge mclk);
    endclocking
    default disable iff (!rst_n);

    // A long result reaches the flags only when no control instruction competes.
    sequence s_long_result;
        alu_flags_en && alu_size == regfile_pkg::SIZE_LONG && ctl_op == regfile_pkg::CTL_NONE;
    endsequence

    // The |=> properties tie a registered output to the inputs taken one edge before; p_reset_mask, p_irq and p_fetch check the same cycle.
    property p_zero;
        s_long_result |=> condition_flags[2] == ($past(alu_result) == 32'h0);
    endproperty
    property p_or;
        ctl_op == regfile_pkg::CTL_OR && !exc_start
            |=> condition_flags == ($past(condition_flags) | $past(ctl_imm));
    endproperty
    property p_reset_mask;
        $rose(rst_n) |-> condition_flags[7];
    endproperty
    property p_exc_mask;
        exc_start |=> condition_flags[7];
    endproperty
    property p_irq;
        irq_accept == (nmi_pending || (irq_pending && !condition_flags[7]));
    endproperty
    property p_fetch;
        fetch_addr == {next_instruction_pointer[23:1], 1'b0};
    endproperty
    property p_vector;
        vector_load |=> next_instruction_pointer == $past(vector_data);
    endproperty
    property p_stack;
        stack_wr_en && !wr_en |=> stack_pointer == $past(stack_wr_data);
    endproperty

    a_zero: assert property (p_zero) else $error("Zero flag wrong.");
    a_or: assert property (p_or) else $error("Flag OR wrong.");
    a_reset_mask: assert property (p_reset_mask) else $error("Mask clear after reset.");
    a_exc_mask: assert property (p_exc_mask) else $error("Mask not set.");
    a_irq: assert property (p_irq) else $error("Interrupt gating wrong.");
    a_fetch: assert property (p_fetch) else $error("Fetch address wrong.");
    a_vector: assert property (p_vector) else $error("Vector not loaded.");
    a_stack: assert property (p_stack) else $error("Stack pointer not written.");
endmodule : regfile_asserts

// file: test/tb_top.sv
`timescale 1ns/1ns

// Random traffic checked every cycle against a model of the register state.
module tb_top;
    logic mclk, rst_n, wr_en, stack_wr_en, ptr_load, vector_load, alu_flags_en, alu_hc_en;
    logic alu_sub, alu_v, alu_c_en, alu_c, exc_start, irq_pending, nmi_pending;
    logic irq_accept, cond_true;
    logic [1:0] rd_a_sel, rd_b_sel, wr_sel;
    logic [2:0] rd_a_index, rd_b_index, wr_index;
    logic [3:0] cond_code;
    logic [7:0] ctl_imm, condition_flags, fl;
    logic [23:0] ptr_load_data, vector_data, next_instruction_pointer, fetch_addr, ptr;
    logic [31:0] wr_data, stack_wr_data, alu_result, alu_op_a, alu_op_b;
    logic [31:0] rd_a_data, rd_b_data, stack_pointer;
    logic [31:0] seed = 32'hf882771c;
    logic [31:0] regs [8];
    regfile_pkg::op_size_e rd_a_size, rd_b_size, wr_size, alu_size;
    regfile_pkg::ctl_op_e ctl_op;
    int n_errors = 0;
    int checks = 0;

    cpu_register_file_pc_ccr dut (.*);

    // Xorshift source; a fixed start keeps every run identical.
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction : rnd

    // Size helpers: code 3 is not a size, so it folds onto long.
    function automatic regfile_pkg::op_size_e sz(logic [1:0] v);
        return regfile_pkg::op_size_e'(v == 2'h3 ? 2'h2 : v);
    endfunction : sz
    function automatic logic [1:0] sl(regfile_pkg::op_size_e s, logic h);
        return s == regfile_pkg::SIZE_LONG ? 2'h0 : {s == regfile_pkg::SIZE_WORD, h};
    endfunction : sl
    function automatic logic [31:0] msk(regfile_pkg::op_size_e s);
        return s == regfile_pkg::SIZE_LONG ? '1 : s == regfile_pkg::SIZE_WORD ? 32'hffff : 32'hff;
    endfunction : msk
    function automatic int sft(regfile_pkg::op_size_e s, logic [1:0] sel);
        return sel[0] && s != regfile_pkg::SIZE_LONG ? (s == regfile_pkg::SIZE_WORD ? 16 : 8) : 0;
    endfunction : sft

    // Branch conditions come in pairs, the odd code being the inverse of the even one.
    function automatic logic cond(logic [3:0] c, logic [7:0] f);
        logic t;
        case (c[3:1])
            3'h0: t = 1'b1;
            3'h1: t = !(f[0] | f[2]);
            3'h2: t = !f[0];
            3'h3: t = !f[2];
            3'h4: t = !f[1];
            3'h5: t = !f[3];
            3'h6: t = !(f[3] ^ f[1]);
            default: t = !(f[2] | (f[3] ^ f[1]));
        endcase
        return t ^ c[0];
    endfunction : cond

    task automatic check(logic [31:0] seen, logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("ERROR at %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic tally_and_finish();
        if (n_errors == 0 && checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : tally_and_finish

    // Advance the model with the inputs the design samples at this edge.
    task automatic step();
        logic [31:0] m;
        logic [31:0] h;
        int s;
        if (!rst_n) begin
            foreach (regs[i]) regs[i] = 32'h0;
            ptr = 24'h0;
            fl = regfile_pkg::FLAGS_RESET;
            return;
        end
        if (stack_wr_en && !(wr_en && wr_index == 3'h7)) regs[7] = stack_wr_data;
        m = msk(wr_size);
        s = sft(wr_size, wr_sel);
        if (wr_en) regs[wr_index] = (regs[wr_index] & ~(m << s)) | ((wr_data & m) << s);
        if (vector_load) ptr = vector_data;
        else if (ptr_load) ptr = ptr_load_data;
        case (ctl_op)
            regfile_pkg::CTL_LOAD: fl = ctl_imm;
            regfile_pkg::CTL_AND: fl = fl & ctl_imm;
            regfile_pkg::CTL_OR: fl = fl | ctl_imm;
            regfile_pkg::CTL_XOR: fl = fl ^ ctl_imm;
            default: if (alu_flags_en) begin
                m = msk(alu_size);
                h = m >> 4;
                fl[3] = (alu_result & m) > (m >> 1);
                fl[2] = (alu_result & m) == 32'h0;
                fl[1] = alu_v;
                if (alu_c_en) fl[0] = alu_c;
                if (alu_hc_en) fl[5] = alu_sub ? (alu_op_a & h) < (alu_op_b & h)
                    : ((alu_op_a & h) + (alu_op_b & h)) > h;
            end
        endcase
        if (exc_start) fl[7] = 1'b1;
    endtask : step

    // New random inputs, sizes always paired with a select that fits them.
    task automatic drive();
        logic [31:0] a;
        logic [31:0] b;
        logic [31:0] x;
        logic [31:0] y;
        a = rnd();
        b = rnd();
        x = rnd();
        y = rnd();
        // Result is the real sum or difference, so half carry follows the operands.
        if (b[20] & b[21]) y = a[2] ? x : -x;
        {wr_en, stack_wr_en, ptr_load, alu_flags_en} <= a[7:4];
        {alu_hc_en, alu_sub, alu_v, alu_c_en} <= a[3:0];
        {alu_c, irq_pending, cond_code, ctl_imm} <= a[21:8];
        exc_start <= &a[24:22];
        nmi_pending <= &a[26:25];
        vector_load <= &a[28:27];
        ctl_op <= a[29] ? regfile_pkg::CTL_NONE : regfile_pkg::ctl_op_e'({1'b0, a[31:30]} + 3'h1);
        {wr_index, rd_a_index, rd_b_index} <= b[8:0];
        wr_size <= sz(b[10:9]);
        wr_sel <= sl(sz(b[10:9]), b[11]);
        rd_a_size <= sz(b[13:12]);
        rd_a_sel <= sl(sz(b[13:12]), b[14]);
        rd_b_size <= sz(b[16:15]);
        rd_b_sel <= sl(sz(b[16:15]), b[17]);
        alu_size <= sz(b[19:18]);
        alu_result <= a[2] ? x - y : x + y;
        {ptr_load_data, vector_data} <= {rnd(), b[31:16]};
        wr_data <= rnd();
        stack_wr_data <= rnd();
        alu_op_a <= x;
        alu_op_b <= y;
    endtask : drive

    initial begin
        mclk = 1'b0;
        forever #50 mclk = ~mclk;
    end

    // The run takes about 4016 cycles; this limit leaves more than double.
    initial begin
        #1000000;
        n_errors++;
        tally_and_finish();
    end

    // Main sequence with a second reset in mid-run.
    initial begin
        rst_n = 1'b0;
        drive();
        repeat (16) @(posedge mclk);
        for (int i = 0; i < 4000; i++) begin
            step();
            drive();
            rst_n <= i != 2000;
            @(negedge mclk);
            check(rd_a_data, (regs[rd_a_index] >> sft(rd_a_size, rd_a_sel)) & msk(rd_a_size));
            check(rd_b_data, (regs[rd_b_index] >> sft(rd_b_size, rd_b_sel)) & msk(rd_b_size));
            check(stack_pointer, regs[7]);
            check(next_instruction_pointer, ptr);
            check(fetch_addr, {ptr[23:1], 1'b0});
            check(condition_flags, fl);
            check(irq_accept, nmi_pending | irq_pending & ~fl[7]);
            check(cond_true, cond(cond_code, fl));
            @(posedge mclk);
        end
        tally_and_finish();
    end
endmodule : tb_top

bind cpu_register_file_pc_ccr regfile_asserts chk (.*);
